// ===== hdl/addr_decode_pkg.sv
// Constants for the system address decoder: region bases, limits and target codes.
// Assumes a 32-bit byte address and one clock shared with the bus masters.
package addr_decode_pkg;

  localparam int ADDR_W = 32;

  // Target selected for an access
  typedef enum logic [4:0] {
    TGT_NONE, TGT_ROM0, TGT_ROM1, TGT_ROM2, TGT_RAM0, TGT_CACHE_CTRL, TGT_EMU,
    TGT_DEVCFG, TGT_CLKMULT, TGT_RTCOUNT, TGT_ASP0_REG, TGT_ASP1_REG, TGT_ASP2_REG,
    TGT_SPI0, TGT_SPI1, TGT_I2C0, TGT_I2C1, TGT_ASP0_DATA, TGT_ASP1_DATA,
    TGT_ASP2_DATA, TGT_MOVER_CTRL, TGT_MOVER_HI_CFG, TGT_MOVER_HI_DPM,
    TGT_MOVER_LO_CFG, TGT_MOVER_LO_DPM, TGT_DRAM_SPACE, TGT_ASYNC_SPACE,
    TGT_EXTMEM_REGS
  } target_type;

  localparam int NUM_REGIONS = 27;

  localparam logic [31:0] REGION_BASE [NUM_REGIONS] = '{
    32'h0000_0000, 32'h0004_0000, 32'h0008_0000, 32'h1000_0000, 32'h2000_0000,
    32'h3000_0000, 32'h4000_0000, 32'h4100_0000, 32'h4200_0000, 32'h4400_0000,
    32'h4500_0000, 32'h4600_0000, 32'h4700_0000, 32'h4800_0000, 32'h4900_0000,
    32'h4A00_0000, 32'h5400_0000, 32'h5500_0000, 32'h5600_0000, 32'h6000_0000,
    32'h6100_0000, 32'h6100_8000, 32'h6200_0000, 32'h6200_8000, 32'h8000_0000,
    32'h9000_0000, 32'hF000_0000
  };

  localparam logic [31:0] REGION_END [NUM_REGIONS] = '{
    32'h0003_FFFF, 32'h0007_FFFF, 32'h000B_FFFF, 32'h1002_FFFF, 32'h2000_001F,
    32'h3FFF_FFFF, 32'h4000_0083, 32'h4100_015F, 32'h4200_00A3, 32'h4400_02BF,
    32'h4500_02BF, 32'h4600_02BF, 32'h4700_007F, 32'h4800_007F, 32'h4900_007F,
    32'h4A00_007F, 32'h54FF_FFFF, 32'h55FF_FFFF, 32'h56FF_FFFF, 32'h6000_008F,
    32'h6100_0FFF, 32'h6100_81FF, 32'h6200_0FFF, 32'h6200_81FF, 32'h8FFF_FFFF,
    32'h9FFF_FFFF, 32'hF000_00BF
  };

  // One bit per region: byte and word access allowed
  localparam logic [NUM_REGIONS-1:0] REGION_BYTE_OK = 27'h3A0_000F;

  // Emulation region is reserved for the debugger
  localparam int EMU_INDEX = 5;

  // Byte-writable top byte of the DRAM config register
  localparam logic [31:0] DRAM_CFG_ADDR = 32'hF000_0008;
  localparam logic [1:0] DRAM_CFG_TOP_LANE = 2'h3;

  // Access size encoding
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  localparam logic [4:0] TGT_FIRST = 5'h01;

endpackage : addr_decode_pkg

// ===== hdl/system_address_decoder.sv
// System address decoder: one registered routing decision per request.
// Assumes masters hold a request for one cycle and accept a result one cycle later.
// Operation
// - Three 256 KB read-only pages from address zero are decoded, byte and word allowed.
// - The 192 KB internal RAM page is decoded, byte and word allowed.
// - The 32-byte cache control window is decoded and takes whole words only.
// - The peripheral register windows are decoded as word-only regions.
// - Any word anywhere in an audio serial data window goes to that port's data path.
// - Each data mover unit's 4 KB configuration memory is decoded, word only.
// - Each data mover unit's 512-byte dual-port memory is decoded, byte and word allowed.
// - The external DRAM space goes to the DRAM chip select, byte and word.
// - The external asynchronous space goes to the asynchronous chip select.
// - Controller registers take words only, except a byte write to the DRAM config top byte.
module system_address_decoder
  import addr_decode_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic reqValid,
  input wire logic [31:0] reqAddr,
  input wire logic [1:0] reqSize,
  input wire logic reqWrite,
  output logic rspValid,
  output target_type rspTarget,
  output logic rspError,
  output logic rspByteOk,
  output logic dramSelect,
  output logic asyncSelect
);

  logic [NUM_REGIONS-1:0] hit;
  logic anyHit;
  logic byteOk;
  logic subWord;
  logic cfgByteWrite;
  target_type tgt;
  logic err;

  logic rspValid_q, rspValid_d;
  target_type rspTarget_q, rspTarget_d;
  logic rspError_q, rspError_d;
  logic rspByteOk_q, rspByteOk_d;

  // Range compare per region; ranges never overlap so at most one bit is set
  genvar g;
  generate
    for (g = 0; g < NUM_REGIONS; g++) begin : g_hit
      assign hit[g] = (reqAddr >= REGION_BASE[g]) && (reqAddr <= REGION_END[g]);
    end
  endgenerate

  always_comb begin
    tgt = TGT_NONE;
    for (int i = 0; i < NUM_REGIONS; i++) begin
      if (hit[i]) begin
        tgt = target_type'(TGT_FIRST + 5'(i));
      end
    end
  end

  assign anyHit = |hit;
  assign byteOk = |(hit & REGION_BYTE_OK);
  assign subWord = reqSize != SIZE_WORD;
  // Lets software enter self-refresh without a DRAM init sequence
  assign cfgByteWrite = reqWrite && (reqSize == SIZE_BYTE)
    && (reqAddr[31:2] == DRAM_CFG_ADDR[31:2]) && (reqAddr[1:0] == DRAM_CFG_TOP_LANE);
  // Emulation hits are refused too, so a stray master cannot disturb the debugger
  assign err = !anyHit || hit[EMU_INDEX]
    || (subWord && !byteOk && !cfgByteWrite);

  always_comb begin
    rspValid_d = reqValid;
    rspTarget_d = rspTarget_q;
    rspError_d = rspError_q;
    rspByteOk_d = rspByteOk_q;
    if (reqValid) begin
      rspError_d = err;
      rspTarget_d = err ? TGT_NONE : tgt;
      rspByteOk_d = byteOk;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rspValid_q <= 1'b0;
      rspTarget_q <= TGT_NONE;
      rspError_q <= 1'b0;
      rspByteOk_q <= 1'b0;
    end else begin
      rspValid_q <= rspValid_d;
      rspTarget_q <= rspTarget_d;
      rspError_q <= rspError_d;
      rspByteOk_q <= rspByteOk_d;
    end
  end

  assign rspValid = rspValid_q;
  assign rspTarget = rspTarget_q;
  assign rspError = rspError_q;
  assign rspByteOk = rspByteOk_q;
  assign dramSelect = rspValid_q && (rspTarget_q == TGT_DRAM_SPACE);
  assign asyncSelect = rspValid_q && (rspTarget_q == TGT_ASYNC_SPACE);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_valid_follows: assert property (reqValid |=> rspValid)
    else $error("Response missing after request");
  a_unmapped_error: assert property (reqValid && !anyHit |=> rspError && rspTarget == TGT_NONE)
    else $error("Unmapped address not refused");
  a_rom_byte_ok: assert property (reqValid && reqAddr <= 32'h000B_FFFF
    |=> !rspError && rspByteOk)
    else $error("Read-only page byte access refused");
  a_ram_route: assert property (reqValid && reqAddr[31:16] == 16'h1001
    |=> rspTarget == TGT_RAM0)
    else $error("RAM page misrouted");
  a_cache_word_only: assert property (reqValid && reqAddr[31:5] == 27'h100_0000 && subWord
    |=> rspError)
    else $error("Cache control sub-word access allowed");
  a_periph_word_only: assert property (reqValid && hit[8] && subWord |=> rspError)
    else $error("Peripheral sub-word access allowed");
  a_asp_data_any: assert property (reqValid && reqAddr[31:24] == 8'h55 && !subWord
    |=> rspTarget == TGT_ASP1_DATA && !rspError)
    else $error("Audio data window misrouted");
  a_mover_cfg: assert property (reqValid && reqAddr[31:12] == 20'h62000 && !subWord
    |=> rspTarget == TGT_MOVER_LO_CFG)
    else $error("Mover config memory misrouted");
  a_mover_dpm: assert property (reqValid && reqAddr[31:9] == 23'h30_8040
    |=> rspTarget == TGT_MOVER_HI_DPM && !rspError)
    else $error("Mover data memory misrouted");
  a_dram_select: assert property (reqValid && reqAddr[31:28] == 4'h8
    |=> dramSelect && !asyncSelect)
    else $error("DRAM select wrong");
  a_async_select: assert property (reqValid && reqAddr[31:28] == 4'h9 |=> asyncSelect)
    else $error("Async select wrong");
  a_cfg_byte_write: assert property (reqValid && cfgByteWrite |=> !rspError)
    else $error("Config top byte write refused");
  a_emu_refused: assert property (reqValid && reqAddr[31:28] == 4'h3 |=> rspError)
    else $error("Emulation region not refused");

  // Response timing and holding
  a_rsp_idle_low: assert property (!reqValid |=> !rspValid)
    else $error("Response without request");
  a_error_no_target: assert property (rspValid && rspError |-> rspTarget == TGT_NONE)
    else $error("Refused access still names a target");
  a_target_holds: assert property (!reqValid |=> $stable(rspTarget) && $stable(rspError))
    else $error("Idle response fields changed");
  a_byteok_no_error: assert property (rspValid && rspByteOk |-> !rspError)
    else $error("Byte-capable region refused");

  // Internal memories and control window
  a_rom0_route: assert property (reqValid && reqAddr[31:18] == 14'h0000
    |=> rspTarget == TGT_ROM0 && rspByteOk)
    else $error("First read-only page misrouted");
  a_rom1_route: assert property (reqValid && reqAddr[31:18] == 14'h0001
    |=> rspTarget == TGT_ROM1 && rspByteOk)
    else $error("Second read-only page misrouted");
  a_rom2_route: assert property (reqValid && reqAddr[31:18] == 14'h0002
    |=> rspTarget == TGT_ROM2 && rspByteOk)
    else $error("Third read-only page misrouted");
  a_ram_byte_ok: assert property (reqValid && reqSize == SIZE_BYTE
    && reqAddr >= 32'h1000_0000 && reqAddr <= 32'h1002_FFFF |=> !rspError && rspByteOk)
    else $error("RAM byte access refused");
  a_cache_word_ok: assert property (reqValid && reqAddr[31:5] == 27'h100_0000
    && !subWord |=> rspTarget == TGT_CACHE_CTRL && !rspError)
    else $error("Cache control word access refused");

  // Peripheral and audio windows
  a_periph_sub_word: assert property (reqValid && reqAddr[31:28] == 4'h4 && subWord
    |=> rspError)
    else $error("Peripheral space sub-word access allowed");
  a_devcfg_route: assert property (reqValid && reqAddr[31:8] == 24'h40_0000
    && reqAddr[7:0] <= 8'h83 && !subWord |=> rspTarget == TGT_DEVCFG)
    else $error("Configuration window misrouted");
  a_asp_sub_word: assert property (reqValid && reqAddr[31:24] >= 8'h54
    && reqAddr[31:24] <= 8'h56 && subWord |=> rspError)
    else $error("Audio data sub-word access allowed");
  a_asp0_data: assert property (reqValid && reqAddr[31:24] == 8'h54 && !subWord
    |=> rspTarget == TGT_ASP0_DATA)
    else $error("First audio data window misrouted");
  a_asp2_data: assert property (reqValid && reqAddr[31:24] == 8'h56 && !subWord
    |=> rspTarget == TGT_ASP2_DATA)
    else $error("Third audio data window misrouted");

  // Mover memories
  a_mover_cfg_word: assert property (reqValid && reqAddr[31:12] == 20'h6_2000
    && subWord |=> rspError)
    else $error("Mover config sub-word access allowed");
  a_mover_hi_cfg: assert property (reqValid && reqAddr[31:12] == 20'h6_1000
    && !subWord |=> rspTarget == TGT_MOVER_HI_CFG && !rspError)
    else $error("High mover config memory misrouted");
  a_mover_lo_dpm: assert property (reqValid && reqAddr[31:9] == 23'h31_0040
    |=> rspTarget == TGT_MOVER_LO_DPM && !rspError && rspByteOk)
    else $error("Low mover data memory misrouted");

  // External spaces and controller registers
  a_dram_byte_ok: assert property (reqValid && reqAddr[31:28] == 4'h8
    |=> rspTarget == TGT_DRAM_SPACE && rspByteOk && !rspError)
    else $error("DRAM space access refused");
  a_async_byte_ok: assert property (reqValid && reqAddr[31:28] == 4'h9
    |=> rspTarget == TGT_ASYNC_SPACE && rspByteOk && !dramSelect)
    else $error("Async space access refused");
  a_regs_word_only: assert property (reqValid && reqAddr[31:8] == 24'hF0_0000
    && subWord && !(reqWrite && reqSize == SIZE_BYTE && reqAddr[7:0] == 8'h0B) |=> rspError)
    else $error("Controller register sub-word access allowed");
  a_regs_word_ok: assert property (reqValid && reqAddr[31:8] == 24'hF0_0000
    && reqAddr[7:0] <= 8'hBF && !subWord |=> rspTarget == TGT_EXTMEM_REGS)
    else $error("Controller register word misrouted");
  a_cfg_byte_target: assert property (reqValid && reqWrite && reqSize == SIZE_BYTE
    && reqAddr == 32'hF000_000B |=> rspTarget == TGT_EXTMEM_REGS && !rspError)
    else $error("Config top byte write misrouted");
  a_unmapped_gap: assert property (reqValid && (reqAddr[31:28] == 4'h7
    || (reqAddr[31:28] >= 4'hA && reqAddr[31:28] <= 4'hE))
    |=> rspError && rspTarget == TGT_NONE)
    else $error("Unmapped space not refused");

  c_dram: cover property (reqValid ##1 dramSelect);
  c_error: cover property (reqValid ##1 rspError);
  c_cfg_byte: cover property (reqValid && cfgByteWrite);
  c_back_to_back: cover property (reqValid [*3]);
  c_audio_data: cover property (reqValid ##1 rspTarget == TGT_ASP2_DATA);

endmodule : system_address_decoder

// ===== verification/bus_master_model.sv
// Bus master model: one single-cycle request per call.
// Assumes the bench samples the answer when access returns.
module bus_master_model (
  input wire logic mclk,
  output logic reqValid,
  output logic [31:0] reqAddr,
  output logic [1:0] reqSize,
  output logic reqWrite
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    reqValid = 1'h0;
    reqAddr = 32'h0000_0000;
    reqSize = 2'h0;
    reqWrite = 1'h0;
  end
  // Stays inside region limits unless a scenario asks otherwise
  task automatic access(input logic [31:0] a, input logic [1:0] s, input logic w);
    @(posedge mclk);
    #1;
    reqValid = 1'h1;
    reqAddr = a;
    reqSize = s;
    reqWrite = w;
    @(posedge mclk);
    #1;
    reqValid = 1'h0;
    // Released bus must not show stale values
    reqAddr = ~a;
    reqSize = ~s;
    reqWrite = ~w;
  endtask : access
endmodule : bus_master_model

// ===== verification/tb_top.sv
// Testbench: decoder driven by the master model, each answer checked.
// Assumes 200 MHz clock and answers one cycle after each request.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import addr_decode_pkg::*;
  `define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED at %0t: got %h want %h", $time, g, e); end end
  logic mclk, rst_b, reqValid, reqWrite, rspValid, rspError, rspByteOk, dramSelect, asyncSelect;
  logic [31:0] reqAddr;
  logic [1:0] reqSize;
  target_type rspTarget;
  int error_cnt, comparisons;
  initial begin
    mclk = 1'h0;
    forever #2.5 mclk = ~mclk;
  end
  bus_master_model u_bus_master_model (.mclk(mclk), .reqValid(reqValid), .reqAddr(reqAddr),
    .reqSize(reqSize), .reqWrite(reqWrite));
  system_address_decoder u_system_address_decoder (.mclk(mclk), .rst_b(rst_b),
    .reqValid(reqValid), .reqAddr(reqAddr), .reqSize(reqSize), .reqWrite(reqWrite),
    .rspValid(rspValid), .rspTarget(rspTarget), .rspError(rspError), .rspByteOk(rspByteOk),
    .dramSelect(dramSelect), .asyncSelect(asyncSelect));
  // Byte flag x means not judged
  task automatic pr(input logic [31:0] a, input logic [1:0] s, input logic w,
      input target_type t, input logic b);
    u_bus_master_model.access(a, s, w);
    `CHK(rspValid, 1'h1)
    `CHK(rspTarget, t)
    `CHK(rspError, t == TGT_NONE)
    `CHK(dramSelect, t == TGT_DRAM_SPACE)
    `CHK(asyncSelect, t == TGT_ASYNC_SPACE)
    if (t != TGT_NONE && b !== 1'hx) `CHK(rspByteOk, b)
    // One cycle later the strobes drop and the routing fields hold
    @(posedge mclk);
    #1;
    `CHK(rspValid, 1'h0)
    `CHK(dramSelect | asyncSelect, 1'h0)
    `CHK(rspTarget, t)
  endtask : pr
  task automatic t_mem();
    pr(32'h0000_0000, 2'h0, 1'h0, TGT_ROM0, 1'h1);
    pr(32'h0007_FFFC, 2'h2, 1'h0, TGT_ROM1, 1'h1);
    pr(32'h000B_FFFF, 2'h0, 1'h0, TGT_ROM2, 1'h1);
    pr(32'h000C_0000, 2'h2, 1'h0, TGT_NONE, 1'hx);
    pr(32'h1002_FFFF, 2'h0, 1'h1, TGT_RAM0, 1'h1);
    pr(32'h1000_0000, 2'h3, 1'h0, TGT_RAM0, 1'h1);
    pr(32'h1003_0000, 2'h2, 1'h0, TGT_NONE, 1'hx);
  endtask : t_mem
  task automatic t_ctrl();
    pr(32'h2000_001C, 2'h2, 1'h1, TGT_CACHE_CTRL, 1'h0);
    pr(32'h2000_0000, 2'h0, 1'h1, TGT_NONE, 1'hx);
    pr(32'h2000_0020, 2'h2, 1'h0, TGT_NONE, 1'hx);
    pr(32'h3000_0000, 2'h2, 1'h0, TGT_NONE, 1'hx);
    pr(32'h3FFF_FFFC, 2'h2, 1'h1, TGT_NONE, 1'hx);
  endtask : t_ctrl
  // Last word of each window, then a halfword at its base
  task automatic t_periph();
    for (int i = 6; i < 16; i++) begin
      pr(REGION_END[i] & 32'hFFFF_FFFC, 2'h2, 1'h0, target_type'(i + 1), 1'h0);
      pr(REGION_BASE[i], 2'h1, 1'h1, TGT_NONE, 1'hx);
    end
    pr(32'h4300_0000, 2'h2, 1'h0, TGT_NONE, 1'hx);
    pr(32'h4700_0000, 2'h3, 1'h0, TGT_NONE, 1'hx);
  endtask : t_periph
  task automatic t_audio();
    pr(32'h5400_0000, 2'h2, 1'h1, TGT_ASP0_DATA, 1'h0);
    pr(32'h55FF_FFFC, 2'h2, 1'h0, TGT_ASP1_DATA, 1'h0);
    pr(32'h5612_3458, 2'h2, 1'h1, TGT_ASP2_DATA, 1'h0);
    pr(32'h5400_0003, 2'h0, 1'h0, TGT_NONE, 1'hx);
  endtask : t_audio
  task automatic t_mover();
    pr(32'h6100_0FFC, 2'h2, 1'h1, TGT_MOVER_HI_CFG, 1'h0);
    pr(32'h6200_0000, 2'h2, 1'h0, TGT_MOVER_LO_CFG, 1'h0);
    pr(32'h6200_0004, 2'h0, 1'h1, TGT_NONE, 1'hx);
    pr(32'h6100_1000, 2'h2, 1'h0, TGT_NONE, 1'hx);
    pr(32'h6000_008C, 2'h2, 1'h1, TGT_MOVER_CTRL, 1'h0);
    pr(32'h6000_0000, 2'h0, 1'h0, TGT_NONE, 1'hx);
    pr(32'h6100_81FF, 2'h0, 1'h1, TGT_MOVER_HI_DPM, 1'h1);
    pr(32'h6200_81FC, 2'h2, 1'h0, TGT_MOVER_LO_DPM, 1'h1);
  endtask : t_mover
  task automatic t_ext();
    pr(32'h8FFF_FFFF, 2'h0, 1'h0, TGT_DRAM_SPACE, 1'h1);
    pr(32'h8000_0000, 2'h2, 1'h1, TGT_DRAM_SPACE, 1'h1);
    pr(32'h9FFF_FFFF, 2'h0, 1'h1, TGT_ASYNC_SPACE, 1'h1);
    pr(32'hF000_000B, 2'h0, 1'h1, TGT_EXTMEM_REGS, 1'h0);
    pr(32'hF000_000B, 2'h0, 1'h0, TGT_NONE, 1'hx);
    pr(32'hF000_0008, 2'h0, 1'h1, TGT_NONE, 1'hx);
    pr(32'hF000_00BC, 2'h2, 1'h0, TGT_EXTMEM_REGS, 1'h0);
    pr(32'hF000_00C0, 2'h2, 1'h0, TGT_NONE, 1'hx);
    pr(32'h7000_0000, 2'h2, 1'h0, TGT_NONE, 1'hx);
    pr(32'hA000_0000, 2'h0, 1'h1, TGT_NONE, 1'hx);
  endtask : t_ext
  task automatic conclude();
    if (error_cnt == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  initial begin
    rst_b = 1'h0;
    error_cnt = 0;
    comparisons = 0;
    repeat (20) @(posedge mclk);
    #1;
    `CHK(rspValid, 1'h0)
    `CHK(rspTarget, TGT_NONE)
    `CHK(rspError | rspByteOk | dramSelect | asyncSelect, 1'h0)
    rst_b = 1'h1;
    t_mem();
    t_ctrl();
    t_periph();
    t_audio();
    t_mover();
    t_ext();
    conclude();
  end
  // About 2000 cycles, ten times the expected run
  initial begin
    #10000;
    error_cnt++;
    conclude();
  end
endmodule : tb_top
